// *** asiocf_regs.sv ***
/*
 * Conversion setup and sense buffer power registers with decoded
 * selections for both conversions and the five buffer power controls.
 * Assumes a register access port on core_clk fed by the serial framing
 * logic, and a pulse from the channel function register with the values
 * that function imposes on the first conversion fields.
 */
`timescale 1ns/1ns
`default_nettype none

module asiocf_regs
	import asiocf_pkg::*;
(
	input wire logic core_clk, // core clock, 250 MHz
	input wire logic nrst, // async reset, active low
	input wire logic reg_wr_en, // register write strobe
	input wire logic reg_rd_en, // register read strobe
	input wire logic [7:0] reg_addr, // register address
	input wire logic [15:0] reg_wdata, // write data
	output logic [15:0] reg_rdata, // read data, registered
	output logic reg_rd_hit, // read hit a mapped register
	input wire logic chfunc_wr, // channel function written
	input wire logic chfunc_span_upd, // overwrite first span
	input wire logic [SPAN_W-1:0] chfunc_span, // new first span
	input wire logic chfunc_sel_upd, // overwrite first input
	input wire logic [NODE_W-1:0] chfunc_input_sel, // new first input
	output logic [15:0] adc_conversion_config, // setup word
	output logic [4:0] first_conversion_rate, // one-hot rate
	output logic [4:0] second_conversion_rate, // one-hot rate
	output logic first_conversion_notch, // 50/60 Hz rejection
	output logic second_conversion_notch, // 50/60 Hz rejection
	output logic [6:0] first_conversion_span, // one-hot span
	output logic [6:0] second_conversion_span, // one-hot span
	output logic [3:0] first_conversion_input_select, // one-hot node
	output logic [3:0] second_conversion_input_select, // one-hot node
	output logic ground_sense_buffer_power, // 1 full power
	output logic low_freq_sense_buffer_power, // 1 full power
	output logic high_freq_sense_buffer_power, // 1 full power
	output logic external_sense_two_buffer_power, // 1 full power
	output logic external_sense_one_buffer_power // 1 full power
);
	// ==========================================================
	// address decode
	wire logic hit_adc;
	wire logic hit_pwr;
	wire logic wr_adc;
	wire logic wr_pwr;
	wire logic rd_adc;
	wire logic rd_pwr;

	assign hit_adc = (reg_addr == ADDR_ADC_CFG);
	assign hit_pwr = (reg_addr == ADDR_BUF_PWR);
	assign wr_adc = reg_wr_en && hit_adc;
	assign wr_pwr = reg_wr_en && hit_pwr;
	assign rd_adc = reg_rd_en && hit_adc;
	assign rd_pwr = reg_rd_en && hit_pwr;

	// ==========================================================
	// conversion setup register
	logic [15:0] adc_cfg_ff;
	wire logic [15:0] nxt_adc_cfg;
	wire logic [15:0] host_adc;
	wire logic [15:0] ovr_mask;
	wire logic [15:0] ovr_val;

	// host writes land first, then the channel function override
	assign host_adc = wr_adc ? reg_wdata : adc_cfg_ff;
	assign ovr_mask = (chfunc_wr && chfunc_span_upd ? S1_MASK : RD_ZERO) |
		(chfunc_wr && chfunc_sel_upd ? N1_MASK : RD_ZERO);
	assign ovr_val = (16'(chfunc_span) << S1_LSB) |
		(16'(chfunc_input_sel) << N1_LSB);
	assign nxt_adc_cfg = (host_adc & ~ovr_mask) |
		(ovr_val & ovr_mask);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			adc_cfg_ff <= ADC_CFG_RST;
		end else begin
			adc_cfg_ff <= nxt_adc_cfg;
		end
	end

	assign adc_conversion_config = adc_cfg_ff;

	// ==========================================================
	// buffer power register, reserved bits are not stored
	logic [BUF_N-1:0] buf_pwr_ff;
	wire logic [BUF_N-1:0] nxt_buf_pwr;

	assign nxt_buf_pwr = wr_pwr ? reg_wdata[BUF_N-1:0] :
		buf_pwr_ff;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			buf_pwr_ff <= BUF_PWR_RST[BUF_N-1:0];
		end else begin
			buf_pwr_ff <= nxt_buf_pwr;
		end
	end

	assign ground_sense_buffer_power = buf_pwr_ff[BUF_GND];
	assign low_freq_sense_buffer_power = buf_pwr_ff[BUF_LF];
	assign high_freq_sense_buffer_power = buf_pwr_ff[BUF_HF];
	assign external_sense_two_buffer_power =
		buf_pwr_ff[BUF_EXT2];
	assign external_sense_one_buffer_power =
		buf_pwr_ff[BUF_EXT1];

	// ==========================================================
	// readback, answered one cycle after the strobe
	logic [15:0] rdata_ff;
	logic rd_hit_ff;
	wire logic [15:0] nxt_rdata;

	assign nxt_rdata = rd_adc ? adc_cfg_ff :
		rd_pwr ? 16'(buf_pwr_ff) : RD_ZERO;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= RD_ZERO;
			rd_hit_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rd_hit_ff <= rd_adc || rd_pwr;
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_rd_hit = rd_hit_ff;

	// ==========================================================
	// field extraction, index 0 first conversion, 1 second
	wire logic [1:0][RATE_W-1:0] rate_code;
	wire logic [1:0][SPAN_W-1:0] span_code;
	wire logic [1:0][NODE_W-1:0] node_code;

	assign rate_code[0] = adc_cfg_ff[R1_LSB +: RATE_W];
	assign rate_code[1] = adc_cfg_ff[R2_LSB +: RATE_W];
	assign span_code[0] = adc_cfg_ff[S1_LSB +: SPAN_W];
	assign span_code[1] = adc_cfg_ff[S2_LSB +: SPAN_W];
	assign node_code[0] = adc_cfg_ff[N1_LSB +: NODE_W];
	assign node_code[1] = adc_cfg_ff[N2_LSB +: NODE_W];

	// ==========================================================
	// decoders and registered selections per conversion
	logic [1:0][4:0] rate_sel_ff;
	logic [1:0] notch_ff;
	logic [1:0][6:0] span_sel_ff;
	logic [1:0][3:0] node_sel_ff;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_conv
			asiocf_conv_if cif();

			assign cif.rate_code = rate_code[g];
			assign cif.span_code = span_code[g];
			assign cif.node_code = node_code[g];

			asiocf_rate_dec u_rate (
				.cif(cif.rate_dec)
			);

			asiocf_span_dec u_span (
				.cif(cif.span_dec)
			);

			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					rate_sel_ff[g] <= RSEL_20;
					notch_ff[g] <= 1'b1;
					span_sel_ff[g] <= SSEL_0_12V;
					node_sel_ff[g] <= NSEL_ONE;
				end else begin
					rate_sel_ff[g] <= cif.rate_sel;
					notch_ff[g] <= cif.notch;
					span_sel_ff[g] <= cif.span_sel;
					node_sel_ff[g] <= cif.node_sel;
				end
			end
		end
	endgenerate

	assign first_conversion_rate = rate_sel_ff[0];
	assign second_conversion_rate = rate_sel_ff[1];
	assign first_conversion_notch = notch_ff[0];
	assign second_conversion_notch = notch_ff[1];
	assign first_conversion_span = span_sel_ff[0];
	assign second_conversion_span = span_sel_ff[1];
	assign first_conversion_input_select = node_sel_ff[0];
	assign second_conversion_input_select = node_sel_ff[1];

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_pwr_write;
		wr_pwr;
	endsequence

	sequence s_pwr_read;
		rd_pwr;
	endsequence

	sequence s_adc_plain_write;
		wr_adc && !chfunc_wr;
	endsequence

	sequence s_chfunc_span;
		chfunc_wr && chfunc_span_upd;
	endsequence

	a_adc_reset_val: assert property (
		$rose(nrst) |-> adc_cfg_ff == ADC_CFG_RST
	) else $error("setup register reset value wrong");

	a_pwr_reset_val: assert property (
		$rose(nrst) |-> buf_pwr_ff == BUF_PWR_RST[BUF_N-1:0]
	) else $error("buffer power reset value wrong");

	a_second_rate_map: assert property (
		s_adc_plain_write ##1 (rate_code[1] == RATE_9K6)
		|=> second_conversion_rate == RSEL_9K6
	) else $error("second rate 9.6k decode wrong");

	a_first_rate_map: assert property (
		rate_code[0] == RATE_1K2 |=> first_conversion_rate == RSEL_1K2
	) else $error("first rate 1.2k decode wrong");

	a_rate_fallback: assert property (
		rate_code[1] > RATE_9K6 |=> second_conversion_rate == RSEL_20
	) else $error("undefined rate code not 20 SPS");

	a_notch_rates: assert property (
		(rate_code[0] == RATE_1K2 || rate_code[0] == RATE_10)
		|=> first_conversion_notch == (rate_code[0] == RATE_10)
		&& $stable(adc_cfg_ff) or !$stable(adc_cfg_ff)
	) else $error("rejection flag wrong");

	a_span_map: assert property (
		span_code[1] == SPAN_PM104M |=> second_conversion_span == SSEL_PM104M
	) else $error("second span decode wrong");

	a_span_fallback: assert property (
		span_code[0] == 3'h7 |=> first_conversion_span == SSEL_0_12V
	) else $error("undefined span code not 0 to 12 V");

	a_chfunc_span: assert property (
		s_chfunc_span |=> span_code[0] == $past(chfunc_span)
	) else $error("function override of first span lost");

	a_second_node: assert property (
		##1 second_conversion_input_select == NSEL_ONE << $past(node_code[1])
	) else $error("second input select decode wrong");

	a_chfunc_node: assert property (
		chfunc_wr && chfunc_sel_upd
		|=> ##1 first_conversion_input_select ==
		NSEL_ONE << $past(chfunc_input_sel, 2)
	) else $error("function override of first input lost");

	a_buf_write: assert property (
		s_pwr_write |=> ground_sense_buffer_power == $past(reg_wdata[BUF_GND])
	) else $error("ground sense buffer bit not written");

	a_resv_zero: assert property (
		s_pwr_read |=> (reg_rdata & ~BUF_PWR_MASK) == RD_ZERO && reg_rd_hit
	) else $error("reserved bits not read as zero");
endmodule

`default_nettype wire

// *** asiocf_pkg.sv ***
/*
 * Constants shared by the conversion setup and buffer power registers:
 * addresses, reset values, field positions, rate/span/node codes and the
 * one-hot codes of the decoded selections.
 * Assumes a 16-bit register word and 8-bit register addresses.
 */
// Contract
// - Conversion setup register resets to 0x2400: rates 001, spans and nodes zero.
// - Second rate bits 15..13: 000 10, 001 20, 010 1.2k, 011 4.8k, 100 9.6k SPS.
// - First rate bits 12..10 use the same five-code rate encoding.
// - Rate codes 101, 110, 111 select 20 SPS.
// - Rates of codes 000 and 001 give 50/60 Hz rejection; faster rates none.
// - Second span bits 9..7 map seven codes to the seven input spans.
// - Span code 111 selects the 0 V to 12 V span.
// - First span bits 6..4 use the same seven-code span encoding.
// - Channel function writes may overwrite the first span field.
// - Second input select bits 3..2: ext1-gnd, ext2-gnd, ext2-ext1, ground short.
// - First input select bits 1..0: lf-gnd, hf-lf, ext2-ext1, lf-ext1.
// - Channel function writes may overwrite the first input select field.
// - Buffer power register resets to 0x001F; bits 15..5 reserved read-only.
// - Bit 4: ground sense buffer low power at 0, full power at 1.
// - Bit 3 low frequency sense buffer, bit 2 high frequency sense buffer.
// - Bit 1 external sense two buffer, bit 0 external sense one buffer.
// - Channel function writes let the device overwrite conversion setup fields.
`default_nettype none

package asiocf_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_ADC_CFG = 8'h02;
	localparam logic [7:0] ADDR_BUF_PWR = 8'h03;
	localparam logic [15:0] ADC_CFG_RST = 16'h2400;
	localparam logic [15:0] BUF_PWR_RST = 16'h001F;
	localparam logic [15:0] BUF_PWR_MASK = 16'h001F;
	localparam logic [15:0] RD_ZERO = 16'h0000;

	// ==========================================================
	// field layout of the conversion setup register
	localparam int RATE_W = 3;
	localparam int SPAN_W = 3;
	localparam int NODE_W = 2;
	localparam int R2_LSB = 13;
	localparam int R1_LSB = 10;
	localparam int S2_LSB = 7;
	localparam int S1_LSB = 4;
	localparam int N2_LSB = 2;
	localparam int N1_LSB = 0;
	localparam logic [15:0] S1_MASK = 16'h0070;
	localparam logic [15:0] N1_MASK = 16'h0003;

	// ==========================================================
	// buffer power bits
	localparam int BUF_N = 5;
	localparam int BUF_GND = 4;
	localparam int BUF_LF = 3;
	localparam int BUF_HF = 2;
	localparam int BUF_EXT2 = 1;
	localparam int BUF_EXT1 = 0;

	// ==========================================================
	// codes and one-hot selections
	typedef logic [RATE_W-1:0] asiocf_rate_t;
	typedef logic [SPAN_W-1:0] asiocf_span_t;
	localparam asiocf_rate_t RATE_10 = 3'h0;
	localparam asiocf_rate_t RATE_20 = 3'h1;
	localparam asiocf_rate_t RATE_1K2 = 3'h2;
	localparam asiocf_rate_t RATE_4K8 = 3'h3;
	localparam asiocf_rate_t RATE_9K6 = 3'h4;
	localparam logic [4:0] RSEL_10 = 5'h01;
	localparam logic [4:0] RSEL_20 = 5'h02;
	localparam logic [4:0] RSEL_1K2 = 5'h04;
	localparam logic [4:0] RSEL_4K8 = 5'h08;
	localparam logic [4:0] RSEL_9K6 = 5'h10;
	localparam asiocf_span_t SPAN_0_12V = 3'h0;
	localparam asiocf_span_t SPAN_PM12V = 3'h1;
	localparam asiocf_span_t SPAN_PM2V5 = 3'h2;
	localparam asiocf_span_t SPAN_N2V5_0 = 3'h3;
	localparam asiocf_span_t SPAN_0_2V5 = 3'h4;
	localparam asiocf_span_t SPAN_0_625M = 3'h5;
	localparam asiocf_span_t SPAN_PM104M = 3'h6;
	localparam logic [6:0] SSEL_0_12V = 7'h01;
	localparam logic [6:0] SSEL_PM12V = 7'h02;
	localparam logic [6:0] SSEL_PM2V5 = 7'h04;
	localparam logic [6:0] SSEL_N2V5_0 = 7'h08;
	localparam logic [6:0] SSEL_0_2V5 = 7'h10;
	localparam logic [6:0] SSEL_0_625M = 7'h20;
	localparam logic [6:0] SSEL_PM104M = 7'h40;
	localparam logic [3:0] NSEL_ONE = 4'h1;
endpackage

`default_nettype wire

// *** asiocf_conv_if.sv ***
/*
 * Carries one conversion's codes to the decoders and the decoded
 * selections back to the register block.
 * Assumes the register block drives the codes from its flip-flops.
 */
`timescale 1ns/1ns
`default_nettype none

interface asiocf_conv_if;
	import asiocf_pkg::*;
	asiocf_rate_t rate_code;
	asiocf_span_t span_code;
	logic [NODE_W-1:0] node_code;
	logic [4:0] rate_sel;
	logic notch;
	logic [6:0] span_sel;
	logic [3:0] node_sel;
	modport rate_dec (input rate_code, output rate_sel, notch);
	modport span_dec (input span_code, node_code, output span_sel, node_sel);
endinterface

`default_nettype wire

// *** asiocf_rate_dec.sv ***
/*
 * Decodes a conversion rate code into a one-hot rate selection and a
 * mains rejection flag.
 * Assumes codes come from a register on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module asiocf_rate_dec
	import asiocf_pkg::*;
(
	asiocf_conv_if.rate_dec cif // codes in, selection out
);
	// unlisted codes fall through to 20 SPS
	assign cif.rate_sel = (cif.rate_code == RATE_10) ? RSEL_10 :
		(cif.rate_code == RATE_1K2) ? RSEL_1K2 :
		(cif.rate_code == RATE_4K8) ? RSEL_4K8 :
		(cif.rate_code == RATE_9K6) ? RSEL_9K6 : RSEL_20;

	// only the two slow rates reject 50/60 Hz
	assign cif.notch = (cif.rate_sel == RSEL_10) ||
		(cif.rate_sel == RSEL_20);
endmodule

`default_nettype wire

// *** asiocf_span_dec.sv ***
/*
 * Decodes a conversion span code into a one-hot span selection and an
 * input node code into a one-hot node selection.
 * Assumes codes come from a register on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module asiocf_span_dec
	import asiocf_pkg::*;
(
	asiocf_conv_if.span_dec cif // codes in, selection out
);
	// code 111 falls through to the 0 V to 12 V span
	assign cif.span_sel = (cif.span_code == SPAN_PM12V) ? SSEL_PM12V :
		(cif.span_code == SPAN_PM2V5) ? SSEL_PM2V5 :
		(cif.span_code == SPAN_N2V5_0) ? SSEL_N2V5_0 :
		(cif.span_code == SPAN_0_2V5) ? SSEL_0_2V5 :
		(cif.span_code == SPAN_0_625M) ? SSEL_0_625M :
		(cif.span_code == SPAN_PM104M) ? SSEL_PM104M :
		SSEL_0_12V;

	// all four node codes are defined
	assign cif.node_sel = NSEL_ONE << cif.node_code;
endmodule

`default_nettype wire

// *** asiocf_host.sv ***
/*
 * Host model: issues register writes, reads and channel function pulses.
 * Assumes core_clk from the bench; all lines change at falling edges.
 */
`timescale 1ns/1ns
`default_nettype none

module asiocf_host
	import asiocf_pkg::*;
(
	input wire logic core_clk, // core clock
	output logic reg_wr_en, // write strobe
	output logic reg_rd_en, // read strobe
	output logic [7:0] reg_addr, // address
	output logic [15:0] reg_wdata, // write data
	output logic chfunc_wr, // channel function pulse
	output logic chfunc_span_upd, // span overwrite
	output logic [SPAN_W-1:0] chfunc_span, // span value
	output logic chfunc_sel_upd, // input overwrite
	output logic [NODE_W-1:0] chfunc_input_sel // input value
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		chfunc_wr = 1'b0;
		chfunc_span_upd = 1'b0;
		chfunc_span = 3'h0;
		chfunc_sel_upd = 1'b0;
		chfunc_input_sel = 2'h0;
	end
	// ==========================================================
	// released strobes, address and write data never keep the last value; the channel function fields do
	task automatic idle();
		@(negedge core_clk);
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		chfunc_wr = 1'b0;
		reg_wdata = ~reg_wdata;
		reg_addr = ~reg_addr;
	endtask
	// setup writes are only issued while conversions stay stopped
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		idle();
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		idle();
	endtask
	task automatic chf(input logic w, su, input logic [2:0] s,
			input logic nu, input logic [1:0] n);
		@(negedge core_clk);
		chfunc_wr = w;
		chfunc_span_upd = su;
		chfunc_span = s;
		chfunc_sel_upd = nu;
		chfunc_input_sel = n;
		idle();
	endtask
endmodule

`default_nettype wire

// *** adc_setup_and_buffer_power_regs_test.sv ***
/*
 * Self-checking bench for the setup and buffer power registers.
 * Assumes the host model drives every register bus input.
 */
`timescale 1ns/1ns
`default_nettype none

module adc_setup_and_buffer_power_regs_test;
	import asiocf_pkg::*;
	logic core_clk, nrst, reg_wr_en, reg_rd_en, reg_rd_hit, chfunc_wr;
	logic chfunc_span_upd, chfunc_sel_upd, rd_d;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, adc_conversion_config, exp_cfg;
	logic [2:0] chfunc_span;
	logic [1:0] chfunc_input_sel;
	logic [4:0] first_conversion_rate, second_conversion_rate, exp_buf;
	logic first_conversion_notch, second_conversion_notch;
	logic [6:0] first_conversion_span, second_conversion_span;
	logic [3:0] first_conversion_input_select, second_conversion_input_select;
	logic ground_sense_buffer_power, low_freq_sense_buffer_power;
	logic high_freq_sense_buffer_power, external_sense_two_buffer_power;
	logic external_sense_one_buffer_power;
	logic [16:0] rd_q[$];
	logic [54:0] dec_q[$];
	int fail_count, tests_run, cycles;
	event chk_ev;

	asiocf_regs u_asiocf_regs (.core_clk, .nrst, .reg_wr_en, .reg_rd_en,
		.reg_addr, .reg_wdata, .reg_rdata, .reg_rd_hit, .chfunc_wr,
		.chfunc_span_upd, .chfunc_span, .chfunc_sel_upd, .chfunc_input_sel,
		.adc_conversion_config, .first_conversion_rate,
		.second_conversion_rate, .first_conversion_notch,
		.second_conversion_notch, .first_conversion_span,
		.second_conversion_span, .first_conversion_input_select,
		.second_conversion_input_select, .ground_sense_buffer_power,
		.low_freq_sense_buffer_power, .high_freq_sense_buffer_power,
		.external_sense_two_buffer_power, .external_sense_one_buffer_power);
	asiocf_host u_asiocf_host (.core_clk, .reg_wr_en, .reg_rd_en, .reg_addr,
		.reg_wdata, .chfunc_wr, .chfunc_span_upd, .chfunc_span,
		.chfunc_sel_upd, .chfunc_input_sel);

	// ==========================================================
	// expected decode
	function automatic logic [4:0] rsel(input logic [2:0] c);
		return (c > 3'h4) ? 5'h02 : 5'h01 << c;
	endfunction
	function automatic logic [6:0] ssel(input logic [2:0] c);
		return (c == 3'h7) ? 7'h01 : 7'h01 << c;
	endfunction
	function automatic logic [54:0] dec(input logic [15:0] c,
			input logic [4:0] b);
		return {c, rsel(c[15:13]), rsel(c[12:10]),
			c[15:13] <= 3'h1 || c[15:13] > 3'h4,
			c[12:10] <= 3'h1 || c[12:10] > 3'h4,
			ssel(c[9:7]), ssel(c[6:4]), 4'h1 << c[3:2], 4'h1 << c[1:0], b};
	endfunction

	// ==========================================================
	// compare and report
	task automatic cmp(input string what, input logic [54:0] e, s);
		tests_run++;
		if (e !== s) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// stimulus helpers
	task automatic rd(input logic [7:0] a, input logic [15:0] d,
			input logic h);
		rd_q.push_back({h, d});
		u_asiocf_host.rd(a);
	endtask
	task automatic check_dec();
		dec_q.push_back(dec(exp_cfg, exp_buf));
		repeat (2) @(negedge core_clk);
		->chk_ev;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		if (a == ADDR_ADC_CFG) exp_cfg = d;
		if (a == ADDR_BUF_PWR) exp_buf = d[4:0];
		u_asiocf_host.wr(a, d);
		check_dec();
	endtask
	task automatic reset_dut();
		@(negedge core_clk);
		nrst = 1'b0;
		exp_cfg = ADC_CFG_RST;
		exp_buf = 5'h1F;
		repeat (6) @(negedge core_clk);
		nrst = 1'b1;
		check_dec();
		rd(ADDR_ADC_CFG, 16'h2400, 1'b1);
		rd(ADDR_BUF_PWR, 16'h001F, 1'b1);
	endtask

	// ==========================================================
	// watchers
	always @(posedge core_clk) rd_d <= reg_rd_en;
	always @(negedge core_clk) begin
		if (rd_d) begin
			if (rd_q.size() == 0) cmp("read", 55'h0, 55'h1);
			else cmp("read", 55'(rd_q.pop_front()),
				55'({reg_rd_hit, reg_rdata}));
		end
	end
	always begin
		@(chk_ev);
		cmp("decode", dec_q.pop_front(), {adc_conversion_config,
			second_conversion_rate, first_conversion_rate,
			second_conversion_notch, first_conversion_notch,
			second_conversion_span, first_conversion_span,
			second_conversion_input_select, first_conversion_input_select,
			ground_sense_buffer_power, low_freq_sense_buffer_power,
			high_freq_sense_buffer_power, external_sense_two_buffer_power,
			external_sense_one_buffer_power});
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [2:0] k;
		logic [15:0] d;
		fail_count = 0;
		tests_run = 0;
		cycles = 0;
		nrst = 1'b0;
		rd_d = 1'b0;
		d = 16'($urandom(32'hBF7C));
		reset_dut();
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			d = {k, ~k, k, ~k, k[1:0], ~k[1:0]};
			wr(ADDR_ADC_CFG, d);
			rd(ADDR_ADC_CFG, d, 1'b1);
		end
		for (int i = 0; i < 8; i++) begin
			d = 16'($urandom());
			if (i < 5) d[4:0] = ~(5'h01 << i);
			wr(ADDR_BUF_PWR, d);
			rd(ADDR_BUF_PWR, {11'h000, d[4:0]}, 1'b1);
		end
		wr(8'h04, 16'($urandom()));
		rd(8'h04, 16'h0000, 1'b0);
		for (int i = 0; i < 8; i++) begin
			d = 16'($urandom());
			u_asiocf_host.chf(d[0], d[1], d[4:2], d[5], d[7:6]);
			if (d[0] && d[1]) exp_cfg[6:4] = d[4:2];
			if (d[0] && d[5]) exp_cfg[1:0] = d[7:6];
			check_dec();
			rd(ADDR_ADC_CFG, exp_cfg, 1'b1);
		end
		reset_dut();
		repeat (4) @(negedge core_clk);
		wrap_up();
	end
endmodule

`default_nettype wire
